// ==== hbtm_pkg.sv ====
// Constants, field layouts and timing tables for the half-bridge timing and mode registers.
package hbtm_pkg;

    // Register access geometry.
    localparam int REG_W = 16;
    localparam int OFFSET_W = 5;
    localparam int NUM_BRIDGES = 4;
    localparam int NUM_CHANNELS = 3;

    // Register offsets and the bank each one answers in.
    localparam logic [4:0] FW_TIMING_OFFSET = 5'h05;
    localparam logic [4:0] MODE_OFFSET = 5'h06;
    localparam logic [4:0] PWM_OFFSET = 5'h07;
    localparam logic FW_TIMING_BANK = 1'h1;
    localparam logic MODE_BANK = 1'h0;
    localparam logic PWM_BANK = 1'h0;

    // Reset values.
    localparam logic [15:0] FW_TIMING_RESET = 16'h4924;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] PWM_RESET = 16'h6420;

    // Writable bits; all others are read-only zero.
    localparam logic [15:0] FW_TIMING_WMASK = 16'h7FFF;
    localparam logic [15:0] MODE_WMASK = 16'h00FF;
    localparam logic [15:0] PWM_WMASK = 16'h7FFF;

    // Freewheel timing field positions.
    localparam int CODE_W = 3;
    localparam int FW_CCP1_LSB = 0;
    localparam int FW_BLANK1_LSB = 3;
    localparam int FW_CCP2_LSB = 6;
    localparam int FW_BLANK2_LSB = 9;
    localparam int FW_CCP3_LSB = 12;

    // External set 3 and set 4 code positions on the side input.
    localparam int EXT_BLANK3_LSB = 0;
    localparam int EXT_CCP4_LSB = 3;
    localparam int EXT_BLANK4_LSB = 6;

    // Mode and PWM field layout.
    localparam int MODE_FIELD_W = 2;
    localparam int SET_SEL_W = 2;
    localparam int PWM_STRIDE = 4;
    localparam int PWM_EN_LSB = 0;
    localparam int PWM_SEL_LSB = 1;
    localparam int PWM_SEL_USED_W = 2;

    // Static drive codes of one half-bridge.
    typedef enum logic [1:0] {
        HBTM_MODE_HIZ = 2'b00,
        HBTM_MODE_LOW = 2'b01,
        HBTM_MODE_HIGH = 2'b10,
        HBTM_MODE_RSVD = 2'b11
    } hbtm_mode_t;

    // Clock rate and the typical times per code, in nanoseconds.
    localparam int CLK_FREQ_MHZ = 125;
    localparam int NS_PER_US = 1000;
    localparam int CYC_W = 11;
    localparam int CCP_TIME_NS [8] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
    localparam int BLANK_TIME_NS [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};

    // Converts a typical time to the nearest whole clock count, never below one.
    function automatic logic [CYC_W-1:0] hbtm_ns_to_cycles(input int ns);
        int c;
        c = (ns * CLK_FREQ_MHZ + NS_PER_US / 2) / NS_PER_US;
        if (c < 1) begin
            c = 1;
        end
        return c[CYC_W-1:0];
    endfunction

endpackage

// ==== hbtm_timing_decode.sv ====
// Picks one of four timing sets for a bridge and turns its codes into clock counts.
`timescale 1ns/10ps
module hbtm_timing_decode (
    input wire logic [1:0] set_select,
    input wire logic [11:0] ccp_codes,
    input wire logic [11:0] blank_codes,
    output logic [10:0] ccp_cycles,
    output logic [10:0] blank_cycles
);

    logic [2:0] ccp_code;
    logic [2:0] blank_code;

    // Set 1 sits in the lowest code slot, set 4 in the highest.
    always_comb begin
        ccp_code = ccp_codes[set_select * hbtm_pkg::CODE_W +: hbtm_pkg::CODE_W];
        blank_code = blank_codes[set_select * hbtm_pkg::CODE_W +: hbtm_pkg::CODE_W];
        ccp_cycles = hbtm_pkg::hbtm_ns_to_cycles(hbtm_pkg::CCP_TIME_NS[ccp_code]);
        blank_cycles = hbtm_pkg::hbtm_ns_to_cycles(hbtm_pkg::BLANK_TIME_NS[blank_code]);
    end

endmodule // hbtm_timing_decode

// ==== hbtm_regs.sv ====
// Freewheel timing, static half-bridge mode and PWM channel setup registers.
`timescale 1ns/10ps
module hbtm_regs #(
    parameter int CYC_W = hbtm_pkg::CYC_W
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    input wire logic REG_BANK,
    input wire logic [4:0] REG_OFFSET,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic [7:0] TIMING_SET_SELECT,
    input wire logic [8:0] FREEWHEEL_SET34_CODES,
    output logic [3:0] BRIDGE_LOW_ON,
    output logic [3:0] BRIDGE_HIGH_ON,
    output logic [3:0] BRIDGE_PWM_OWNED,
    output logic [2:0] PWM_CHANNEL_ENABLE,
    output logic [5:0] PWM_CHANNEL_BRIDGE,
    output logic REG_ERROR,
    output logic [4*CYC_W-1:0] BRIDGE_CCP_CYCLES,
    output logic [4*CYC_W-1:0] BRIDGE_BLANK_CYCLES
);

    localparam int NB = hbtm_pkg::NUM_BRIDGES;
    localparam int NC = hbtm_pkg::NUM_CHANNELS;
    localparam int CW = hbtm_pkg::CODE_W;

    logic [15:0] freewheel_timing_set2;
    logic [15:0] next_freewheel_timing_set2;
    logic [15:0] half_bridge_static_mode;
    logic [15:0] next_half_bridge_static_mode;
    logic [15:0] pwm_channel_setup;
    logic [15:0] next_pwm_channel_setup;
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic hit_fw;
    logic hit_mode;
    logic hit_pwm;
    logic [NB-1:0] conflict;
    logic [NB-1:0] owned;
    logic [NB-1:0] next_low_on;
    logic [NB-1:0] next_high_on;
    logic next_error;
    logic [11:0] ccp_codes;
    logic [11:0] blank_codes;
    logic [4*CYC_W-1:0] ccp_cyc;
    logic [4*CYC_W-1:0] blank_cyc;

    // True when the access addresses the register at the given bank and offset.
    function automatic logic reg_hit(input logic bank, input logic [4:0] offset,
                                     input logic want_bank, input logic [4:0] want_offset);
        return (bank == want_bank) && (offset == want_offset);
    endfunction

    // Counts enabled PWM channels steered to one bridge; the top select bit is ignored.
    function automatic logic [1:0] channels_on_bridge(input logic [15:0] setup,
                                                      input logic [1:0] bridge);
        logic [1:0] n;
        n = 2'h0;
        for (int ch = 0; ch < NC; ch++) begin
            if (setup[ch * hbtm_pkg::PWM_STRIDE + hbtm_pkg::PWM_EN_LSB] &&
                setup[ch * hbtm_pkg::PWM_STRIDE + hbtm_pkg::PWM_SEL_LSB +:
                      hbtm_pkg::PWM_SEL_USED_W] == bridge) begin
                n = n + 2'h1;
            end
        end
        return n;
    endfunction

    // Address decode shared by reads and writes.
    assign hit_fw = reg_hit(REG_BANK, REG_OFFSET, hbtm_pkg::FW_TIMING_BANK,
                            hbtm_pkg::FW_TIMING_OFFSET);
    assign hit_mode = reg_hit(REG_BANK, REG_OFFSET, hbtm_pkg::MODE_BANK, hbtm_pkg::MODE_OFFSET);
    assign hit_pwm = reg_hit(REG_BANK, REG_OFFSET, hbtm_pkg::PWM_BANK,
                             hbtm_pkg::PWM_OFFSET);

    // Register writes; read-only bits are masked off so they stay at zero.
    always_comb begin
        next_freewheel_timing_set2 = freewheel_timing_set2;
        next_half_bridge_static_mode = half_bridge_static_mode;
        next_pwm_channel_setup = pwm_channel_setup;
        if (REG_WRITE && hit_fw) begin
            next_freewheel_timing_set2 = REG_WDATA & hbtm_pkg::FW_TIMING_WMASK;
        end
        if (REG_WRITE && hit_mode) begin
            next_half_bridge_static_mode = REG_WDATA & hbtm_pkg::MODE_WMASK;
        end
        if (REG_WRITE && hit_pwm) begin
            next_pwm_channel_setup = REG_WDATA & hbtm_pkg::PWM_WMASK;
        end
    end

    // Register storage with the documented reset values.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            freewheel_timing_set2 <= hbtm_pkg::FW_TIMING_RESET;
            half_bridge_static_mode <= hbtm_pkg::MODE_RESET;
            pwm_channel_setup <= hbtm_pkg::PWM_RESET;
        end else begin
            freewheel_timing_set2 <= next_freewheel_timing_set2;
            half_bridge_static_mode <= next_half_bridge_static_mode;
            pwm_channel_setup <= next_pwm_channel_setup;
        end
    end

    // Read path; an unmapped address answers zero.
    always_comb begin
        next_rvalid = REG_READ;
        next_rdata = REG_RDATA;
        if (REG_READ) begin
            if (hit_fw) begin
                next_rdata = freewheel_timing_set2;
            end else if (hit_mode) begin
                next_rdata = half_bridge_static_mode;
            end else if (hit_pwm) begin
                next_rdata = pwm_channel_setup;
            end else begin
                next_rdata = 16'h0000;
            end
        end
    end

    // Read answer registers.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            REG_RDATA <= 16'h0000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RDATA <= next_rdata;
            REG_RVALID <= next_rvalid;
        end
    end

    // Bridge drive from static mode, overridden to off by a PWM allocation clash.
    always_comb begin
        for (int b = 0; b < NB; b++) begin
            conflict[b] = channels_on_bridge(pwm_channel_setup, 2'(b)) >= 2'h2;
            owned[b] = channels_on_bridge(pwm_channel_setup, 2'(b)) == 2'h1;
            next_low_on[b] = 1'b0;
            next_high_on[b] = 1'b0;
            case (hbtm_pkg::hbtm_mode_t'(half_bridge_static_mode[b * 2 +: 2]))
                hbtm_pkg::HBTM_MODE_LOW: begin
                    next_low_on[b] = !conflict[b];
                end
                hbtm_pkg::HBTM_MODE_HIGH: begin
                    next_high_on[b] = !conflict[b];
                end
                default: begin
                    next_low_on[b] = 1'b0;
                end
            endcase
        end
        next_error = |conflict;
    end

    // Gather the four timing sets; set 3 partly and set 4 wholly come from outside this block.
    always_comb begin
        ccp_codes = {FREEWHEEL_SET34_CODES[hbtm_pkg::EXT_CCP4_LSB +: CW],
                     freewheel_timing_set2[hbtm_pkg::FW_CCP3_LSB +: CW],
                     freewheel_timing_set2[hbtm_pkg::FW_CCP2_LSB +: CW],
                     freewheel_timing_set2[hbtm_pkg::FW_CCP1_LSB +: CW]};
        blank_codes = {FREEWHEEL_SET34_CODES[hbtm_pkg::EXT_BLANK4_LSB +: CW],
                       FREEWHEEL_SET34_CODES[hbtm_pkg::EXT_BLANK3_LSB +: CW],
                       freewheel_timing_set2[hbtm_pkg::FW_BLANK2_LSB +: CW],
                       freewheel_timing_set2[hbtm_pkg::FW_BLANK1_LSB +: CW]};
    end

    // One timing decoder per bridge, steered by its set select.
    generate
        for (genvar b = 0; b < NB; b++) begin : g_bridge
            hbtm_timing_decode u_decode (
                .set_select(TIMING_SET_SELECT[b * 2 +: 2]),
                .ccp_codes(ccp_codes),
                .blank_codes(blank_codes),
                .ccp_cycles(ccp_cyc[b * CYC_W +: CYC_W]),
                .blank_cycles(blank_cyc[b * CYC_W +: CYC_W])
            );
        end
    endgenerate

    // Output registers for drive, allocation, error and timing counts.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            BRIDGE_LOW_ON <= 4'h0;
            BRIDGE_HIGH_ON <= 4'h0;
            BRIDGE_PWM_OWNED <= 4'h0;
            PWM_CHANNEL_ENABLE <= 3'h0;
            PWM_CHANNEL_BRIDGE <= 6'h00;
            REG_ERROR <= 1'b0;
            BRIDGE_CCP_CYCLES <= '0;
            BRIDGE_BLANK_CYCLES <= '0;
        end else begin
            BRIDGE_LOW_ON <= next_low_on;
            BRIDGE_HIGH_ON <= next_high_on;
            BRIDGE_PWM_OWNED <= owned & ~conflict;
            PWM_CHANNEL_ENABLE <= {pwm_channel_setup[8], pwm_channel_setup[4],
                                   pwm_channel_setup[0]};
            PWM_CHANNEL_BRIDGE <= {pwm_channel_setup[10:9], pwm_channel_setup[6:5],
                                   pwm_channel_setup[2:1]};
            REG_ERROR <= next_error;
            BRIDGE_CCP_CYCLES <= ccp_cyc;
            BRIDGE_BLANK_CYCLES <= blank_cyc;
        end
    end

    // Checks on the register file and the drive it produces.
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    a_fw_reset_value: assert property ($past(RESET) |->
        freewheel_timing_set2 == 16'h4924)
        else $error("freewheel timing not at reset value");

    a_fw_write_decode: assert property ((REG_WRITE && REG_BANK && REG_OFFSET == 5'h05) |=>
        freewheel_timing_set2 == ($past(REG_WDATA) & 16'h7FFF))
        else $error("freewheel timing write not taken");

    a_fw_wrong_bank: assert property ((REG_WRITE && !REG_BANK && REG_OFFSET == 5'h05) |=>
        $stable(freewheel_timing_set2))
        else $error("freewheel timing changed from bank zero");

    a_fw_read_top: assert property ((REG_READ && REG_BANK && REG_OFFSET == 5'h05) |=>
        REG_RVALID && !REG_RDATA[15] && REG_RDATA[14:0] == $past(freewheel_timing_set2[14:0]))
        else $error("freewheel timing read wrong");

    a_mode_read_zero: assert property ((REG_READ && !REG_BANK && REG_OFFSET == 5'h06) |=>
        REG_RDATA[15:8] == 8'h00)
        else $error("mode upper byte not zero");

    a_mode_low_drive: assert property ((half_bridge_static_mode[1:0] == 2'b01 && !conflict[0])
        |=> BRIDGE_LOW_ON[0] && !BRIDGE_HIGH_ON[0])
        else $error("bridge one low side not driven");

    a_mode_rsvd_off: assert property ((half_bridge_static_mode[3:2] == 2'b11) |=>
        !BRIDGE_LOW_ON[1] && !BRIDGE_HIGH_ON[1])
        else $error("reserved mode drives bridge two");

    a_pwm_wrong_bank: assert property ((REG_WRITE && REG_BANK && REG_OFFSET == 5'h07) |=>
        $stable(pwm_channel_setup))
        else $error("pwm setup changed from bank one");

    a_pwm_top_zero: assert property ((REG_READ && !REG_BANK && REG_OFFSET == 5'h07) |=>
        !REG_RDATA[15])
        else $error("pwm setup bit 15 not zero");

    a_clash_flag: assert property ((pwm_channel_setup[0] && pwm_channel_setup[4] &&
        pwm_channel_setup[2:1] == pwm_channel_setup[6:5]) |=> REG_ERROR)
        else $error("channel clash not flagged");

    a_ccp_count: assert property ((TIMING_SET_SELECT[1:0] == 2'b00 &&
        freewheel_timing_set2[2:0] == 3'b000) |=> BRIDGE_CCP_CYCLES[10:0] == 11'h02F)
        else $error("375 ns cross-current count wrong");

    a_blank_count: assert property ((TIMING_SET_SELECT[3:2] == 2'b01 &&
        freewheel_timing_set2[11:9] == 3'b010) |=> BRIDGE_BLANK_CYCLES[21:11] == 11'h09C)
        else $error("1.25 us blank count wrong");

endmodule // hbtm_regs

// ==== hbtm_host_model.sv ====
// Host model that drives the register strobes of the timing and mode registers.
`timescale 1ns/10ps
module hbtm_host_model (
    input wire logic REF_CLK,
    output logic REG_WRITE,
    output logic REG_READ,
    output logic REG_BANK,
    output logic [4:0] REG_OFFSET,
    output logic [15:0] REG_WDATA,
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_RVALID
);
    // The bus idles with both strobes low until the first access.
    initial begin
        REG_WRITE = 1'h0;
        REG_READ = 1'h0;
        REG_BANK = 1'h0;
        REG_OFFSET = 5'h00;
        REG_WDATA = 16'h0000;
    end

    // This host never lowers its drive current, so it never asks for the 16 us codes.
    function automatic logic [15:0] limit_codes(input logic [15:0] data);
        logic [15:0] r;
        r = data;
        for (int f = 0; f < 5; f++) begin
            if (r[3 * f +: 3] == 3'h7) begin
                r[3 * f +: 3] = 3'h6;
            end
        end
        return r;
    endfunction

    // One write strobe; data is inverted afterwards so stale data never looks valid.
    task automatic write_reg(input logic bank, input logic [4:0] off, input logic [15:0] data,
                             output logic [15:0] sent);
        sent = (bank == hbtm_pkg::FW_TIMING_BANK && off == hbtm_pkg::FW_TIMING_OFFSET) ?
            limit_codes(data) : data;
        @(posedge REF_CLK);
        REG_WRITE <= 1'h1;
        REG_BANK <= bank;
        REG_OFFSET <= off;
        REG_WDATA <= sent;
        @(posedge REF_CLK);
        REG_WRITE <= 1'h0;
        REG_WDATA <= ~sent;
    endtask

    // One read strobe, then a bounded wait for the answer.
    task automatic read_reg(input logic bank, input logic [4:0] off, output logic [16:0] got);
        @(posedge REF_CLK);
        REG_READ <= 1'h1;
        REG_BANK <= bank;
        REG_OFFSET <= off;
        @(posedge REF_CLK);
        REG_READ <= 1'h0;
        got = 17'h00000;
        for (int i = 0; i < 3 && got[16] !== 1'b1; i++) begin
            @(posedge REF_CLK);
            if (REG_RVALID === 1'b1) begin
                got = {1'b1, REG_RDATA};
            end
        end
    endtask
endmodule // hbtm_host_model

// ==== test_half_bridge_timing_mode_pwm_regs.sv ====
// Self-checking bench comparing the register slice with a behavioural model.
`timescale 1ns/10ps
module test_half_bridge_timing_mode_pwm_regs;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] tsel = 8'h00;
    logic [8:0] ext = 9'h000;
    logic reg_write, reg_read, reg_bank, reg_rvalid, reg_error;
    logic [4:0] reg_offset;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [16:0] got;
    logic [3:0] low_on, high_on, owned;
    logic [2:0] ch_en;
    logic [5:0] ch_br;
    logic [43:0] ccp_cyc, blank_cyc;
    int errors = 0;
    int n_compared = 0;
    int seed = 65758;
    int fw, md, pw, b, o;
    int ccp_ns[8] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
    int blk_ns[8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};

    // The clock toggles every 4 ns, a period of 8 ns.
    always #4 ref_clk = ~ref_clk;

    hbtm_host_model HOST (.REF_CLK(ref_clk), .REG_WRITE(reg_write), .REG_READ(reg_read),
        .REG_BANK(reg_bank), .REG_OFFSET(reg_offset), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid));

    hbtm_regs DUT (.REF_CLK(ref_clk), .RESET(reset), .REG_WRITE(reg_write),
        .REG_READ(reg_read), .REG_BANK(reg_bank), .REG_OFFSET(reg_offset),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
        .TIMING_SET_SELECT(tsel), .FREEWHEEL_SET34_CODES(ext), .BRIDGE_LOW_ON(low_on),
        .BRIDGE_HIGH_ON(high_on), .BRIDGE_PWM_OWNED(owned), .PWM_CHANNEL_ENABLE(ch_en),
        .PWM_CHANNEL_BRIDGE(ch_br), .REG_ERROR(reg_error), .BRIDGE_CCP_CYCLES(ccp_cyc),
        .BRIDGE_BLANK_CYCLES(blank_cyc));

    // Counts and reports one comparison.
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Model of the three registers; writable bits only, at their own bank and offset.
    function automatic int model_rd(input int bk, input int of);
        if (bk == 1 && of == 5) return fw;
        if (bk == 0 && of == 6) return md;
        if (bk == 0 && of == 7) return pw;
        return 0;
    endfunction

    // Reads one register through the host and compares with the model.
    task automatic rd(input int bk, input int of);
        HOST.read_reg(bk[0], of[4:0], got);
        check({31'h0, got}, {31'h0, 1'b1, 16'(model_rd(bk, of))});
    endtask

    // Works out every drive and timing output from the model and compares.
    task automatic check_outs;
        int sel[3];
        int cnt[4];
        int s, cc, bc;
        logic [3:0] lo, hi, own;
        logic [43:0] ec, eb;
        logic [15:0] p;
        logic err;
        cnt = '{0, 0, 0, 0};
        p = pw[15:0];
        for (int c = 0; c < 3; c++) begin
            sel[c] = (pw >> (4 * c + 1)) & 3;
            if (p[4 * c]) cnt[sel[c]]++;
        end
        for (int k = 0; k < 4; k++) begin
            own[k] = cnt[k] == 1;
            lo[k] = cnt[k] < 2 && ((md >> (2 * k)) & 3) == 1;
            hi[k] = cnt[k] < 2 && ((md >> (2 * k)) & 3) == 2;
            s = (tsel >> (2 * k)) & 3;
            cc = s == 0 ? fw & 7 : s == 1 ? (fw >> 6) & 7 : s == 2 ? (fw >> 12) & 7 : (ext >> 3) & 7;
            bc = s == 0 ? (fw >> 3) & 7 : s == 1 ? (fw >> 9) & 7 : s == 2 ? ext & 7 : (ext >> 6) & 7;
            ec[11 * k +: 11] = 11'((ccp_ns[cc] * 125 + 500) / 1000);
            eb[11 * k +: 11] = 11'((blk_ns[bc] * 125 + 500) / 1000);
        end
        err = cnt[0] > 1 || cnt[1] > 1 || cnt[2] > 1 || cnt[3] > 1;
        check(48'(low_on & high_on), 48'h0);
        check(48'({low_on, high_on, owned, ch_en}), 48'({lo, hi, own, p[8], p[4], p[0]}));
        check(48'({ch_br, reg_error}), 48'({sel[2][1:0], sel[1][1:0], sel[0][1:0], err}));
        check(48'(ccp_cyc), 48'(ec));
        check(48'(blank_cyc), 48'(eb));
    endtask

    // Main sequence: reset values, bank decoding, read-only bits, then random traffic.
    initial begin
        fw = 16'h4924;
        md = 0;
        pw = 16'h6420;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check_outs;
        for (int k = 0; k < 8; k++) rd(k[0], 5 + k / 2);
        for (int k = 5; k < 8; k++) begin
            HOST.write_reg(k == 5, k[4:0], 16'hFFFF, d);
        end
        fw = 16'h6DB6;
        md = 16'h00FF;
        pw = 16'h7FFF;
        for (int k = 5; k < 8; k++) rd(k == 5, k);
        for (int n = 0; n < 400; n++) begin
            b = $random(seed) & 1;
            o = 5 + (($random(seed) & 32'h7FFFFFFF) % 4);
            d = 16'($random(seed));
            @(posedge ref_clk);
            tsel <= 8'($random(seed));
            ext <= 9'($random(seed));
            HOST.write_reg(b[0], o[4:0], d, d);
            if (b == 1 && o == 5) fw = d & 16'h7FFF;
            if (b == 0 && o == 6) md = d & 16'h00FF;
            if (b == 0 && o == 7) pw = d & 16'h7FFF;
            rd(b, o);
            check_outs;
        end
        report_and_stop;
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        report_and_stop;
    end
endmodule // test_half_bridge_timing_mode_pwm_regs
